// ---- rtl/trip_delay_timer.v ----
// Operating-time stage: pick-up with hysteresis, blocking, fixed or
// inverse-time trip delay, configurable release, APB register file.
// Assumes synchronous inputs on pclk and an external curve evaluator
// that returns the inverse-time delay for the ratio and constants shown.
`timescale 1ns/1ns
`include "trip_delay_consts.vh"

// Overview of operation
// - Instant mode trips with start, same cycle
// - Fixed mode trips after delay, pick-up held
// - Inverse mode delay follows measured/setting ratio
// - Release behaviour on early drop-out configurable
// - Delay type selects fixed/inverse, fixed default
// - Definite delay in 5 ms steps, 40 ms default
// - Zero fixed delay means instant operation
// - Inverse mode: definite delay is minimum time
// - Curve series IEC/IEEE, IEC default, inverse only
// - IEC curves: four standard plus param, normal default
// - IEC param uses user constants A, B
// - IEEE family seven curves plus param, ANSI normal
// - IEEE param uses user constants A, B, C
// - Time dial scales inverse delay, 0.05 default
// - Constant A 0.0001 steps, default 0.0860
// - Constant B 0.0001 steps, default 0.1850
// - Constant C default 0.0200, IEEE param only
// - Pick-up drops below 97 % of setting
// - Blocking after start clears start, releases
module trip_delay_timer #(
   parameter TICK_CYCLES = `TICK_NS / `CLK_NS,
   parameter MEAS_W      = 16,
   parameter TIME_W      = 20
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output wire [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire [MEAS_W-1:0] meas_value,
   input  wire              block_in,
   input  wire [TIME_W-1:0] curve_delay_ms,
   output wire [15:0]       eval_ratio,
   output wire              eval_series,
   output wire [2:0]        eval_curve,
   output wire [15:0]       eval_time_dial,
   output wire [19:0]       eval_const_a,
   output wire [19:0]       eval_const_b,
   output wire [19:0]       eval_const_c,
   output wire              pickup_out,
   output wire              start_out,
   output wire              blocked_out,
   output wire              trip_out
);

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function is_mapped;
      input [7:0] a;
      begin
         case (a)
            `OFS_CTRL, `OFS_DEF_DELAY, `OFS_TIME_DIAL, `OFS_CONST_A, `OFS_CONST_B,
            `OFS_CONST_C, `OFS_PICKUP_SET, `OFS_RELEASE, `OFS_STATUS, `OFS_TIMER,
            `OFS_RATIO: is_mapped = 1'b1;
            default:    is_mapped = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [8:0]        ctrl_reg;
   reg  [TIME_W-1:0] def_delay_reg;
   reg  [15:0]       time_dial_reg;
   reg  [19:0]       const_a_reg;
   reg  [19:0]       const_b_reg;
   reg  [19:0]       const_c_reg;
   reg  [MEAS_W-1:0] pickup_set_reg;
   reg  [TIME_W-1:0] release_reg;
   reg  [31:0]       prdata_reg;
   reg               pickup_reg;
   reg               pickup_d_reg;
   reg               start_reg;
   reg               blocked_reg;
   reg               trip_reg;
   reg  [TIME_W-1:0] timer_reg;
   reg  [TIME_W-1:0] rel_cnt_reg;
   reg  [31:0]       tick_cnt_reg;
   reg  [15:0]       ratio_reg;
   reg               eval_series_reg;
   reg  [2:0]        eval_curve_reg;
   reg  [15:0]       eval_time_dial_reg;
   reg  [19:0]       eval_const_a_reg;
   reg  [19:0]       eval_const_b_reg;
   reg  [19:0]       eval_const_c_reg;

   localparam [TIME_W-1:0] DELAY_STEP = `DELAY_STEP_MS;

   wire              wr_en;
   wire              rd_setup;
   wire              inverse_mode;
   wire              ieee_series;
   wire [2:0]        iec_curve;
   wire [2:0]        ieee_curve;
   wire              param_curve;
   wire              release_hold;
   wire              tick;
   wire              instant;
   wire [TIME_W-1:0] target;
   wire              timer_done;
   wire [MEAS_W+7:0] meas_pct;
   wire [MEAS_W+7:0] drop_pct;
   wire              pickup_next;
   wire              pickup_rise;
   wire              releasing;
   wire              release_done;
   wire [31:0]       status_word;
   wire [MEAS_W+7:0] ratio_full;

   assign wr_en    = psel & penable & pwrite & is_mapped(paddr);
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~is_mapped(paddr);
   assign prdata   = prdata_reg;

   // ----------------------------------------
   // Mode and curve selection
   // ----------------------------------------
   assign inverse_mode = ctrl_reg[`CTRL_DELAY_TYPE];
   assign ieee_series  = ctrl_reg[`CTRL_CURVE_SERIES];
   assign iec_curve    = ctrl_reg[`CTRL_IEC_LSB+2:`CTRL_IEC_LSB];
   assign ieee_curve   = ctrl_reg[`CTRL_IEEE_LSB+2:`CTRL_IEEE_LSB];
   assign release_hold = ctrl_reg[`CTRL_RELEASE_HOLD];
   assign param_curve  = ieee_series ? (ieee_curve == `IEEE_PARAM)
                                     : (iec_curve == `IEC_PARAM);

   // Curve settings only reach the evaluator in inverse mode
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eval_series_reg    <= 1'b0;
         eval_curve_reg     <= 3'h0;
         eval_time_dial_reg <= 16'h0000;
         eval_const_a_reg   <= 20'h00000;
         eval_const_b_reg   <= 20'h00000;
         eval_const_c_reg   <= 20'h00000;
      end else begin
         eval_series_reg    <= inverse_mode & ieee_series;
         eval_curve_reg     <= ~inverse_mode ? 3'h0 :
                               (ieee_series ? ieee_curve : iec_curve);
         eval_time_dial_reg <= inverse_mode ? time_dial_reg : 16'h0000;
         eval_const_a_reg   <= (inverse_mode & param_curve) ? const_a_reg : 20'h00000;
         eval_const_b_reg   <= (inverse_mode & param_curve) ? const_b_reg : 20'h00000;
         eval_const_c_reg   <= (inverse_mode & param_curve & ieee_series)
                               ? const_c_reg : 20'h00000;
      end
   end

   assign eval_series    = eval_series_reg;
   assign eval_curve     = eval_curve_reg;
   assign eval_time_dial = eval_time_dial_reg;
   assign eval_const_a   = eval_const_a_reg;
   assign eval_const_b   = eval_const_b_reg;
   assign eval_const_c   = eval_const_c_reg;

   // ----------------------------------------
   // Ratio of measured value to setting (8.8)
   // ----------------------------------------
   // Divide by zero guarded; a zero setting reads as full-scale ratio
   assign ratio_full = (pickup_set_reg == {MEAS_W{1'b0}}) ? {(MEAS_W+8){1'b1}} :
                       ({meas_value, 8'h00} / {8'h00, pickup_set_reg});
   assign eval_ratio = ratio_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_reg <= 16'h0000;
      end else begin
         ratio_reg <= (|ratio_full[MEAS_W+7:16]) ? 16'hFFFF : ratio_full[15:0];
      end
   end

   // ----------------------------------------
   // Pick-up with fixed hysteresis
   // ----------------------------------------
   assign meas_pct = meas_value * 8'd`FULL_PCT;
   assign drop_pct = pickup_set_reg * 8'd`DROPOUT_PCT;
   assign pickup_next = pickup_reg ? (meas_pct >= drop_pct)
                                   : (meas_value >= pickup_set_reg);
   assign pickup_rise = pickup_next & ~pickup_reg;

   // ----------------------------------------
   // Processing tick (1 ms)
   // ----------------------------------------
   assign tick = (tick_cnt_reg == TICK_CYCLES - 1);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= 32'h00000000;
      end else if (tick) begin
         tick_cnt_reg <= 32'h00000000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
   end

   // ----------------------------------------
   // Trip time selection
   // ----------------------------------------
   assign instant = ~inverse_mode & (def_delay_reg == {TIME_W{1'b0}});
   assign target  = ~inverse_mode ? def_delay_reg :
                    ((curve_delay_ms > def_delay_reg) ? curve_delay_ms
                                                      : def_delay_reg);
   assign timer_done = (timer_reg >= target);

   // ----------------------------------------
   // Release bookkeeping
   // ----------------------------------------
   // Hold mode freezes the timer so a quick re-pick-up resumes timing
   assign releasing    = ~start_reg & (timer_reg != {TIME_W{1'b0}} | trip_reg);
   assign release_done = ~release_hold | (rel_cnt_reg >= release_reg);

   // ----------------------------------------
   // Start, blocking and timer
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pickup_reg   <= 1'b0;
         pickup_d_reg <= 1'b0;
         start_reg    <= 1'b0;
         blocked_reg  <= 1'b0;
      end else begin
         pickup_reg   <= pickup_next;
         pickup_d_reg <= pickup_reg;
         if (!pickup_next) begin
            start_reg   <= 1'b0;
            blocked_reg <= 1'b0;
         end else if (pickup_rise) begin
            start_reg   <= ~block_in;
            blocked_reg <= block_in;
         end else if (block_in) begin
            start_reg   <= 1'b0;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_reg   <= {TIME_W{1'b0}};
         rel_cnt_reg <= {TIME_W{1'b0}};
         trip_reg    <= 1'b0;
      end else if (start_reg) begin
         rel_cnt_reg <= {TIME_W{1'b0}};
         if (instant) begin
            trip_reg <= 1'b1;
         end else if (timer_done) begin
            trip_reg <= 1'b1;
         end else if (tick) begin
            timer_reg <= timer_reg + {{(TIME_W-1){1'b0}}, 1'b1};
         end
      end else if (releasing) begin
         if (release_done) begin
            timer_reg   <= {TIME_W{1'b0}};
            trip_reg    <= 1'b0;
            rel_cnt_reg <= {TIME_W{1'b0}};
         end else if (tick) begin
            rel_cnt_reg <= rel_cnt_reg + {{(TIME_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Instant path bypasses the trip flop to meet same-cycle assertion
   assign trip_out    = trip_reg | (start_reg & instant);
   assign start_out   = start_reg;
   assign pickup_out  = pickup_reg;
   assign blocked_out = blocked_reg;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg       <= `RST_CTRL;
         def_delay_reg  <= `RST_DEF_DELAY;
         time_dial_reg  <= `RST_TIME_DIAL;
         const_a_reg    <= `RST_CONST_A;
         const_b_reg    <= `RST_CONST_B;
         const_c_reg    <= `RST_CONST_C;
         pickup_set_reg <= `RST_PICKUP_SET;
         release_reg    <= `RST_RELEASE;
      end else if (wr_en) begin
         case (paddr)
            `OFS_CTRL: begin
               ctrl_reg <= pwdata[8:0];
            end
            `OFS_DEF_DELAY: begin
               // Snapped down to the 5 ms grid
               def_delay_reg <= pwdata[TIME_W-1:0] -
                                (pwdata[TIME_W-1:0] % DELAY_STEP);
            end
            `OFS_TIME_DIAL: begin
               time_dial_reg <= pwdata[15:0];
            end
            `OFS_CONST_A: begin
               const_a_reg <= pwdata[19:0];
            end
            `OFS_CONST_B: begin
               const_b_reg <= pwdata[19:0];
            end
            `OFS_CONST_C: begin
               const_c_reg <= pwdata[19:0];
            end
            `OFS_PICKUP_SET: begin
               pickup_set_reg <= pwdata[MEAS_W-1:0];
            end
            `OFS_RELEASE: begin
               release_reg <= pwdata[TIME_W-1:0];
            end
            default: begin
               ctrl_reg <= ctrl_reg;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register reads (captured in setup cycle)
   // ----------------------------------------
   assign status_word = {28'h0000000, trip_out, blocked_reg, start_reg, pickup_reg};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_setup) begin
         case (paddr)
            `OFS_CTRL:       prdata_reg <= {23'h000000, ctrl_reg};
            `OFS_DEF_DELAY:  prdata_reg <= {{(32-TIME_W){1'b0}}, def_delay_reg};
            `OFS_TIME_DIAL:  prdata_reg <= {16'h0000, time_dial_reg};
            `OFS_CONST_A:    prdata_reg <= {12'h000, const_a_reg};
            `OFS_CONST_B:    prdata_reg <= {12'h000, const_b_reg};
            `OFS_CONST_C:    prdata_reg <= {12'h000, const_c_reg};
            `OFS_PICKUP_SET: prdata_reg <= {{(32-MEAS_W){1'b0}}, pickup_set_reg};
            `OFS_RELEASE:    prdata_reg <= {{(32-TIME_W){1'b0}}, release_reg};
            `OFS_STATUS:     prdata_reg <= status_word;
            `OFS_TIMER:      prdata_reg <= {{(32-TIME_W){1'b0}}, timer_reg};
            `OFS_RATIO:      prdata_reg <= {16'h0000, ratio_reg};
            default:         prdata_reg <= 32'h00000000;
         endcase
      end
   end

endmodule // trip_delay_timer

// ---- rtl/trip_delay_consts.vh ----
// Constants of the protection trip delay timer: register offsets,
// field positions, reset values and timing figures.
// Assumes inclusion by bare name from the rtl folder.
`ifndef TRIP_DELAY_CONSTS_VH
`define TRIP_DELAY_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_DEF_DELAY   8'h04
`define OFS_TIME_DIAL   8'h08
`define OFS_CONST_A     8'h0C
`define OFS_CONST_B     8'h10
`define OFS_CONST_C     8'h14
`define OFS_PICKUP_SET  8'h18
`define OFS_RELEASE     8'h1C
`define OFS_STATUS      8'h20
`define OFS_TIMER       8'h24
`define OFS_RATIO       8'h28

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTRL_DELAY_TYPE    0
`define CTRL_CURVE_SERIES  1
`define CTRL_IEC_LSB       2
`define CTRL_IEEE_LSB      5
`define CTRL_RELEASE_HOLD  8

// ----------------------------------------
// Curve codes
// ----------------------------------------
`define IEC_NORMAL_INVERSE     3'h0
`define IEC_EXTREME_INVERSE    3'h1
`define IEC_VERY_INVERSE       3'h2
`define IEC_LONG_TIME_INVERSE  3'h3
`define IEC_PARAM              3'h4
`define ANSI_NORMAL_INVERSE    3'h0
`define ANSI_VERY_INVERSE      3'h1
`define ANSI_EXTREME_INVERSE   3'h2
`define ANSI_LONG_TIME_INVERSE 3'h3
`define IEEE_MODERATE_INVERSE  3'h4
`define IEEE_VERY_INVERSE      3'h5
`define IEEE_EXTREME_INVERSE   3'h6
`define IEEE_PARAM             3'h7

// ----------------------------------------
// Reset values (times in ms, constants in 0.0001 units)
// ----------------------------------------
`define RST_CTRL        9'h000
`define RST_DEF_DELAY   20'h00028
`define RST_TIME_DIAL   16'h0032
`define RST_CONST_A     20'h0035C
`define RST_CONST_B     20'h0073A
`define RST_CONST_C     20'h000C8
`define RST_PICKUP_SET  16'h0100
`define RST_RELEASE     20'h00000

// ----------------------------------------
// Timing and hysteresis
// ----------------------------------------
`define DELAY_STEP_MS   5
`define TICK_NS         1000000
`define CLK_NS          20
`define DROPOUT_PCT     97
`define FULL_PCT        100

`endif

// ---- verification/trip_delay_sva.sv ----
// Checker: port-level assertions for the trip delay timer.
// Assumes one clock domain, bound onto every trip_delay_timer instance.
`timescale 1ns/1ns
module trip_delay_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        block_in,
   input wire logic [15:0] eval_ratio,
   input wire logic        eval_series,
   input wire logic [2:0]  eval_curve,
   input wire logic [19:0] eval_const_a,
   input wire logic [19:0] eval_const_c,
   input wire logic        pickup_out,
   input wire logic        start_out,
   input wire logic        blocked_out,
   input wire logic        trip_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   AST_UNMAPPED: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
      else $error("unmapped access without error");
   AST_MAPPED: assert property (psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access flagged as error");
   AST_RD_HOLD: assert property (psel && penable && !pwrite |=> $stable(prdata))
      else $error("read data moved after access");
   // ----------------------------------------
   // Timer stage
   // ----------------------------------------
   AST_START_PICKUP: assert property (start_out |-> pickup_out)
      else $error("start without pickup");
   AST_BLOCK_CLR: assert property (start_out && block_in |=> !start_out)
      else $error("start kept under blocking");
   AST_BLOCKED_NOSTART: assert property (blocked_out |-> !start_out)
      else $error("start while blocked");
   AST_PICK_HI: assert property (eval_ratio >= 16'h0100 |-> pickup_out)
      else $error("pickup low at full ratio");
   AST_PICK_LO: assert property (eval_ratio < 16'h00F8 |-> !pickup_out)
      else $error("pickup held below dropout");
   AST_TRIP_START: assert property ($rose(trip_out) |-> start_out)
      else $error("trip rose without start");
   AST_CONST_C: assert property (eval_const_c != 0 |-> eval_series && eval_curve == 3'h7)
      else $error("constant C outside parameterised curve");
   AST_CONST_A: assert property (eval_const_a != 0 |-> eval_curve == (eval_series ? 3'h7 : 3'h4))
      else $error("constant A outside parameterised curve");
   COV_TRIP: cover property ($rose(trip_out));
   COV_BLOCK: cover property (start_out && block_in);
   COV_PARAM: cover property (eval_const_c != 0);
endmodule // trip_delay_sva

bind trip_delay_timer trip_delay_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .block_in(block_in),
   .eval_ratio(eval_ratio), .eval_series(eval_series), .eval_curve(eval_curve), .eval_const_a(eval_const_a),
   .eval_const_c(eval_const_c), .pickup_out(pickup_out), .start_out(start_out),
   .blocked_out(blocked_out), .trip_out(trip_out));

// ---- verification/curve_eval_model.sv ----
// Partner model: inverse-curve evaluator returning a delay in ms.
// Assumes ratio in 8.8 fixed point and time dial in ms.
`timescale 1ns/1ns
module curve_eval_model (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        slow,
   input wire logic [15:0] eval_ratio,
   input wire logic [15:0] eval_time_dial,
   output logic [19:0]     curve_delay_ms
);
   logic [19:0] calc;
   logic [19:0] held;
   // Delay shrinks as the ratio grows
   always_comb calc = (eval_ratio == 16'h0000) ? 20'hFFFFF : 20'(({16'h0000, eval_time_dial} << 8) / eval_ratio);
   // Slow answer lags one more cycle, as a pipelined evaluator would
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held <= 20'hFFFFF;
         curve_delay_ms <= 20'hFFFFF;
      end else begin
         held <= calc;
         curve_delay_ms <= slow ? held : calc;
      end
   end
endmodule // curve_eval_model

// ---- verification/tb.sv ----
// Testbench: APB setup and pick-up stimulus for the trip delay timer.
// Assumes the curve evaluator model on the far side, short ms tick.
`timescale 1ns/1ns
module tb;
   localparam int TICK = 10;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, block_in = 0, slow = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, pickup_out, start_out, blocked_out, trip_out, eval_series;
   logic [15:0] meas_value = 16'h0000, eval_ratio, eval_time_dial;
   logic [19:0] curve_delay_ms, eval_const_a, eval_const_b, eval_const_c;
   logic [2:0]  eval_curve;
   int          num_errors = 0, compares = 0, n, d;
   logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
   logic [31:0] rst [8] = '{32'h0, 32'h28, 32'h32, 32'h35C, 32'h73A, 32'hC8, 32'h100, 32'h0};
   always #10 pclk = ~pclk;
   trip_delay_timer #(.TICK_CYCLES(TICK)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .meas_value, .block_in, .curve_delay_ms, .eval_ratio, .eval_series,
      .eval_curve, .eval_time_dial, .eval_const_a, .eval_const_b, .eval_const_c, .pickup_out, .start_out,
      .blocked_out, .trip_out);
   curve_eval_model u_curve (.pclk, .presetn, .slow, .eval_ratio, .eval_time_dial, .curve_delay_ms);
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic test_done();
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_win(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   function automatic int tgt(input int curve, input int dd);
      return (curve > dd) ? curve : dd;
   endfunction
   // ----------------------------------------
   // Bus and stimulus helpers
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk) penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         num_errors++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wait_sig(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge pclk);
         n++;
      end
      if (n >= lim) begin
         num_errors++;
         test_done();
      end
      @(posedge pclk);
   endtask
   // Pick-up rises, then time from start to trip
   task automatic run_trip(input logic [15:0] m, input int ms);
      meas_value <= m;
      wait_sig(start_out, 1'b1, 20);
      wait_sig(trip_out, 1'b1, ms * TICK + 40);
      chk_win(n, ms ? ms * TICK - TICK - 2 : 0, ms ? ms * TICK + 3 : 0);
      @(posedge pclk);
   endtask
   // Pick-up drops, then time from start fall to trip release
   task automatic drop(input int hold);
      meas_value <= 16'h0000;
      wait_sig(start_out, 1'b0, 5);
      wait_sig(trip_out, 1'b0, hold * TICK + 20);
      chk_win(n, hold ? hold * TICK - TICK - 2 : 0, hold * TICK + 3);
      @(posedge pclk);
   endtask
   initial begin
      #1000000;
      num_errors++;
      test_done();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      n = $urandom(32'h5764);
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      foreach (ofs[i]) begin
         apb(0, ofs[i], 0);
         chk_val(rd, rst[i]);
      end
      apb(0, 8'h30, 0);
      chk_val(err, 1);
      apb(1, 8'h04, 32'h2B);
      apb(0, 8'h04, 0);
      chk_val(rd, 32'h28);
      apb(1, 8'h04, 0);
      run_trip(16'h0200, 0);
      drop(0);
      repeat (3) begin
         d = 5 * (1 + $urandom % 6);
         apb(1, 8'h04, d);
         run_trip(16'h0100 + 16'($urandom % 768), d);
         drop(0);
      end
      meas_value <= 16'h0100;
      wait_sig(start_out, 1'b1, 20);
      meas_value <= 16'h00F9;
      repeat (3) @(posedge pclk);
      chk_val(pickup_out, 1);
      meas_value <= 16'h00F8;
      repeat (3) @(posedge pclk);
      chk_val(pickup_out, 0);
      meas_value <= 16'h0200;
      wait_sig(start_out, 1'b1, 20);
      block_in <= 1;
      wait_sig(start_out, 1'b0, 3);
      meas_value <= 16'h0000;
      repeat (3) @(posedge pclk);
      meas_value <= 16'h0200;
      repeat (3) @(posedge pclk);
      chk_val({blocked_out, start_out}, 2'b10);
      meas_value <= 16'h0000;
      block_in <= 0;
      apb(1, 8'h00, 32'hFE);
      @(posedge pclk);
      chk_val({eval_series, eval_curve}, 0);
      chk_val(eval_time_dial, 0);
      for (int i = 0; i < 8; i++) begin
         apb(1, 8'h00, (i << 5) | 3);
         @(posedge pclk);
         chk_val({eval_series, eval_curve}, 8 | i);
         chk_val(eval_const_c, i == 7 ? 32'hC8 : 0);
      end
      for (int i = 0; i < 5; i++) begin
         apb(1, 8'h00, (i << 2) | 1);
         @(posedge pclk);
         chk_val({eval_series, eval_curve}, i);
         chk_val(eval_const_b, i == 4 ? 32'h73A : 0);
         chk_val(eval_const_a, i == 4 ? 32'h35C : 0);
      end
      apb(1, 8'h00, 1);
      @(posedge pclk);
      chk_val(eval_time_dial, 32'h32);
      foreach (ofs[i]) begin
         if (i == 1) apb(1, 8'h04, 0);
         if (i == 2) apb(1, 8'h04, 40);
         if (i == 3) apb(1, 8'h08, 100);
         slow <= 1'($urandom);
         if (i >= 1 && i <= 3) run_trip(16'h0200, tgt(i == 3 ? 50 : 25, i == 1 ? 0 : 40));
         if (i >= 1 && i <= 3) drop(0);
      end
      apb(1, 8'h00, 32'h100);
      apb(1, 8'h1C, 10);
      apb(1, 8'h04, 5);
      run_trip(16'h0200, 5);
      drop(10);
      apb(0, 8'h24, 0);
      chk_val(rd, 0);
      test_done();
   end
endmodule // tb
